// *** rtl/ahs_home_search.sv ***
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
`include "ahs_regs.svh"
module ahs_home_search #(
  parameter logic [31:0] FILT_MAX_CYC = `AHS_FLT_MAX_US * `AHS_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sensors
  input wire logic home_detect_input_i,
  input wire logic limit_plus_i,
  input wire logic limit_minus_i,
  // motor driver
  output logic drive_pulse_o,
  output logic drive_dir_minus_o,
  output logic deviation_counter_clear_output_o,
  output logic busy_o
);
  // registers
  logic [15:0] plo_q, phi_q, inlog_q, mode1_q, mode2_q, filt_q;
  logic [31:0] accel_q, hispd_q, lospd_q, offset_q;
  logic [31:0] lpos_q, rpos_q;
  ahs_pkg::ahs_state_t state_q, target_q;
  logic run_q, back_seen_q, overshoot_q;
  logic [31:0] speed_q, acc_q, remain_q, wait_q, cclr_cnt_q;
  logic cclr_act_q;
  // bus decode
  logic acc_phase, wr_en, start_cmd, cmd_wr, mapped;
  logic [31:0] rd_mux;
  logic [31:0] param;
  // motion helpers
  logic step, home_raw, home_act, lim_fwd;
  logic [3:0] flt_code;
  logic [31:0] flt_delay, tmr_cyc, cclr_cyc;
  logic [32:0] acc_sum;
  logic same_path;

  assign acc_phase = psel_i && penable_i && !pready_o;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && mapped;
  assign cmd_wr = wr_en && paddr_i == `AHS_OFS_CMD && pwdata_i[`AHS_CMD_AXIS_BIT];
  assign start_cmd = cmd_wr && pwdata_i[7:0] == `AHS_CMD_START;
  assign param = {phi_q, plo_q};

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr_i == `AHS_OFS_CMD) begin
      rd_mux = 32'h0000_0000;
    end else if (paddr_i == `AHS_OFS_PLO) begin
      rd_mux = {16'h0000, plo_q};
    end else if (paddr_i == `AHS_OFS_PHI) begin
      rd_mux = {16'h0000, phi_q};
    end else if (paddr_i == `AHS_OFS_INLOG) begin
      rd_mux = {16'h0000, inlog_q};
    end else if (paddr_i == `AHS_OFS_STAT) begin
      rd_mux = {19'h0_0000, overshoot_q, home_act, busy_o, state_q};
    end else if (paddr_i == `AHS_OFS_LPOS) begin
      rd_mux = lpos_q;
    end else if (paddr_i == `AHS_OFS_RPOS) begin
      rd_mux = rpos_q;
    end else if (paddr_i == `AHS_OFS_MODE1) begin
      rd_mux = {16'h0000, mode1_q};
    end else if (paddr_i == `AHS_OFS_MODE2) begin
      rd_mux = {16'h0000, mode2_q};
    end else begin
      mapped = 1'b0;
    end
  end

  // answer in the second access cycle; writes land on the pready edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= acc_phase;
      pslverr_o <= acc_phase && !mapped;
      prdata_o <= (acc_phase && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      plo_q <= `AHS_RST_WORD;
      phi_q <= `AHS_RST_WORD;
      inlog_q <= `AHS_RST_WORD;
    end else if (wr_en) begin
      if (paddr_i == `AHS_OFS_PLO) begin
        plo_q <= pwdata_i[15:0];
      end else if (paddr_i == `AHS_OFS_PHI) begin
        phi_q <= pwdata_i[15:0];
      end else if (paddr_i == `AHS_OFS_INLOG) begin
        inlog_q <= pwdata_i[15:0];
      end
    end
  end

  // commands latch the parameter; ignored while searching
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode1_q <= `AHS_RST_WORD;
      mode2_q <= `AHS_RST_WORD;
      filt_q <= `AHS_RST_WORD;
      accel_q <= 32'h0000_0000;
      hispd_q <= `AHS_RST_HISPD;
      lospd_q <= `AHS_RST_LOSPD;
      offset_q <= 32'h0000_0000;
    end else if (cmd_wr && !busy_o) begin
      case (pwdata_i[7:0])
        `AHS_CMD_ACCEL: accel_q <= param;
        `AHS_CMD_HISPD: hispd_q <= param;
        `AHS_CMD_LOSPD: lospd_q <= param;
        `AHS_CMD_OFFSET: offset_q <= param;
        `AHS_CMD_MODE1: mode1_q <= plo_q;
        `AHS_CMD_MODE2: mode2_q <= plo_q;
        `AHS_CMD_FILTER: filt_q <= plo_q;
        default: begin
        end
      endcase
    end
  end

  // delay doubles per code, top code gives the full delay
  assign flt_code = filt_q[`AHS_FLT_DLY_LSB +: 4];
  assign flt_delay = (flt_code == 4'h0) ? 32'h0000_0000 :
    (flt_code >= `AHS_FLT_MAX_CODE) ? FILT_MAX_CYC :
    (FILT_MAX_CYC >> (`AHS_FLT_MAX_CODE - flt_code));
  assign home_raw = home_detect_input_i ~^ inlog_q[`AHS_IL_HOME_HI];

  ahs_in_filter u_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(filt_q[`AHS_FLT_HOME_EN]),
    .delay_i(flt_delay),
    .raw_i(home_raw),
    .filt_o(home_act)
  );

  ahs_pulse_gen u_pulse (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(run_q),
    .speed_i(speed_q),
    .step_o(step)
  );

  assign tmr_cyc = mode2_q[`AHS_M2_TMR_EN] ?
    (`AHS_TMR_BASE_CYC << mode2_q[`AHS_M2_TMR_LSB +: 3]) : 32'h0000_0000;
  assign cclr_cyc = `AHS_CCLR_BASE_CYC << mode2_q[`AHS_M2_CCLR_W_LSB +: 3];
  assign lim_fwd = drive_dir_minus_o ? limit_minus_i : limit_plus_i;
  assign acc_sum = {1'b0, acc_q} + {1'b0, accel_q};
  // same signal and direction in both steps
  assign same_path = mode1_q[`AHS_M1_S1_HOME] == !mode1_q[`AHS_M1_S2_LIMSEL] &&
    mode1_q[`AHS_M1_S1_DIR] == mode1_q[`AHS_M1_S2_DIR];

  // sequencer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ahs_pkg::ST_IDLE;
      target_q <= ahs_pkg::ST_IDLE;
      run_q <= 1'b0;
      speed_q <= 32'h0000_0000;
      drive_dir_minus_o <= 1'b0;
      back_seen_q <= 1'b0;
      overshoot_q <= 1'b0;
      wait_q <= 32'h0000_0000;
      remain_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      busy_o <= 1'b0;
    end else begin
      case (state_q)
        ahs_pkg::ST_IDLE: begin
          if (start_cmd) begin
            busy_o <= 1'b1;
            overshoot_q <= 1'b0;
            wait_q <= 32'h0000_0000;
            state_q <= ahs_pkg::ST_WAIT;
            target_q <= (mode1_q[`AHS_M1_S1_EN] && !home_act) ?
              ahs_pkg::ST_S1_RUN : ahs_pkg::ST_S2_SRCH;
          end
        end
        ahs_pkg::ST_WAIT: begin
          if (wait_q != 32'h0000_0000) begin
            wait_q <= wait_q - 32'h0000_0001;
          end else if (target_q == ahs_pkg::ST_S1_RUN) begin
            state_q <= ahs_pkg::ST_S1_RUN;
            speed_q <= hispd_q;
            drive_dir_minus_o <= mode1_q[`AHS_M1_S1_DIR];
            run_q <= 1'b1;
          end else if (target_q == ahs_pkg::ST_S2_SRCH) begin
            if (!mode1_q[`AHS_M1_S2_EN]) begin
              state_q <= ahs_pkg::ST_S3;
            end else if (home_act) begin
              state_q <= ahs_pkg::ST_S2_ESC;
              speed_q <= lospd_q;
              drive_dir_minus_o <= !mode1_q[`AHS_M1_S2_DIR];
              run_q <= 1'b1;
            end else begin
              state_q <= ahs_pkg::ST_S2_SRCH;
              speed_q <= lospd_q;
              drive_dir_minus_o <= mode1_q[`AHS_M1_S2_DIR];
              run_q <= 1'b1;
            end
          end else if (target_q == ahs_pkg::ST_S4_OFS) begin
            if (mode1_q[`AHS_M1_S4_EN] && offset_q != 32'h0000_0000) begin
              state_q <= ahs_pkg::ST_S4_OFS;
              speed_q <= hispd_q;
              drive_dir_minus_o <= offset_q[31];
              remain_q <= offset_q[31] ? (~offset_q + 32'h0000_0001) : offset_q;
              run_q <= 1'b1;
            end else begin
              state_q <= ahs_pkg::ST_END;
            end
          end else begin
            state_q <= target_q;
          end
        end
        ahs_pkg::ST_S1_RUN: begin
          if (home_act) begin
            state_q <= ahs_pkg::ST_S1_DEC;
            acc_q <= 32'h0000_0000;
          end else if (lim_fwd) begin
            run_q <= 1'b0;
            back_seen_q <= 1'b0;
            state_q <= ahs_pkg::ST_S1_BACK;
          end
        end
        ahs_pkg::ST_S1_DEC: begin
          if (speed_q <= lospd_q || speed_q == 32'h0000_0000 || lim_fwd) begin
            run_q <= 1'b0;
            back_seen_q <= 1'b0;
            wait_q <= tmr_cyc;
            if (!home_act && same_path) begin
              overshoot_q <= 1'b1;
              state_q <= ahs_pkg::ST_S1_BACK;
            end else begin
              state_q <= ahs_pkg::ST_WAIT;
              target_q <= ahs_pkg::ST_S2_SRCH;
            end
          end else if (acc_sum >= {1'b0, `AHS_CLK_HZ}) begin
            acc_q <= 32'(acc_sum - {1'b0, `AHS_CLK_HZ});
            speed_q <= speed_q - 32'h0000_0001;
          end else begin
            acc_q <= acc_sum[31:0];
          end
        end
        ahs_pkg::ST_S1_BACK: begin
          // one reverse pass through the active section
          if (!run_q) begin
            run_q <= 1'b1;
            speed_q <= lospd_q;
            drive_dir_minus_o <= !mode1_q[`AHS_M1_S1_DIR];
          end else begin
            if (home_act) begin
              back_seen_q <= 1'b1;
            end
            if ((back_seen_q && !home_act) || lim_fwd) begin
              run_q <= 1'b0;
              wait_q <= tmr_cyc;
              state_q <= ahs_pkg::ST_WAIT;
              target_q <= ahs_pkg::ST_S2_SRCH;
            end
          end
        end
        ahs_pkg::ST_S2_ESC: begin
          if (!home_act || lim_fwd) begin
            // stop once clear; no reversal while pulses run
            run_q <= 1'b0;
            drive_dir_minus_o <= mode1_q[`AHS_M1_S2_DIR];
            state_q <= ahs_pkg::ST_S2_SRCH;
          end
        end
        ahs_pkg::ST_S2_SRCH: begin
          if (home_act || lim_fwd) begin
            run_q <= 1'b0;
            wait_q <= tmr_cyc;
            state_q <= ahs_pkg::ST_WAIT;
            target_q <= ahs_pkg::ST_S3;
          end else if (!run_q) begin
            // restart forward after the escape stop
            run_q <= 1'b1;
          end
        end
        ahs_pkg::ST_S3: begin
          wait_q <= tmr_cyc;
          state_q <= ahs_pkg::ST_WAIT;
          target_q <= ahs_pkg::ST_S4_OFS;
        end
        ahs_pkg::ST_S4_OFS: begin
          if (lim_fwd || (step && remain_q == 32'h0000_0001)) begin
            run_q <= 1'b0;
            state_q <= ahs_pkg::ST_END;
          end else if (step) begin
            remain_q <= remain_q - 32'h0000_0001;
          end
        end
        default: begin
          run_q <= 1'b0;
          busy_o <= 1'b0;
          state_q <= ahs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // step three clears, clears at completion
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lpos_q <= 32'h0000_0000;
      rpos_q <= 32'h0000_0000;
    end else begin
      if ((state_q == ahs_pkg::ST_S3 && mode1_q[`AHS_M1_S3_EN] &&
           mode1_q[`AHS_M1_S3_LPCLR]) ||
          (state_q == ahs_pkg::ST_END && mode2_q[`AHS_M2_LPCLR])) begin
        lpos_q <= 32'h0000_0000;
      end else if (step) begin
        lpos_q <= drive_dir_minus_o ? lpos_q - 32'h0000_0001 : lpos_q + 32'h0000_0001;
      end
      // no encoder: real counter follows the issued pulses
      if ((state_q == ahs_pkg::ST_S3 && mode1_q[`AHS_M1_S3_EN] &&
           mode1_q[`AHS_M1_S3_RPCLR]) ||
          (state_q == ahs_pkg::ST_END && mode2_q[`AHS_M2_RPCLR])) begin
        rpos_q <= 32'h0000_0000;
      end else if (step) begin
        rpos_q <= drive_dir_minus_o ? rpos_q - 32'h0000_0001 : rpos_q + 32'h0000_0001;
      end
    end
  end

  // clear output pulse, width and polarity
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cclr_act_q <= 1'b0;
      cclr_cnt_q <= 32'h0000_0000;
      deviation_counter_clear_output_o <= 1'b0;
    end else begin
      if (state_q == ahs_pkg::ST_S3 && mode1_q[`AHS_M1_S3_EN] &&
          mode1_q[`AHS_M1_S3_CCLR]) begin
        cclr_act_q <= 1'b1;
        cclr_cnt_q <= cclr_cyc;
      end else if (cclr_cnt_q != 32'h0000_0000) begin
        cclr_cnt_q <= cclr_cnt_q - 32'h0000_0001;
      end else begin
        cclr_act_q <= 1'b0;
      end
      deviation_counter_clear_output_o <= cclr_act_q ^ mode2_q[`AHS_M2_CCLR_POL];
    end
  end

  // registered so the pulse pin comes straight from a flop
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_pulse_o <= 1'b0;
    end else begin
      drive_pulse_o <= step;
    end
  end
endmodule : ahs_home_search

// *** rtl/ahs_in_filter.sv ***
`timescale 1ns/10ps
// with en_i set, level passes only after it has been stable for delay_i cycles; with en_i clear it passes straight through
module ahs_in_filter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic [31:0] delay_i,
  // level in and out
  input wire logic raw_i,
  output logic filt_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0000_0000;
      filt_o <= 1'b0;
    end else if (!en_i || raw_i == filt_o) begin
      cnt_q <= 32'h0000_0000;
      filt_o <= en_i ? filt_o : raw_i;
    end else if (cnt_q >= delay_i) begin
      cnt_q <= 32'h0000_0000;
      filt_o <= raw_i;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule : ahs_in_filter

// *** rtl/ahs_pkg.sv ***
package ahs_pkg;

  typedef enum logic [9:0] {
    ST_IDLE    = 10'b00_0000_0001,
    ST_WAIT    = 10'b00_0000_0010,
    ST_S1_RUN  = 10'b00_0000_0100,
    ST_S1_DEC  = 10'b00_0000_1000,
    ST_S1_BACK = 10'b00_0001_0000,
    ST_S2_ESC  = 10'b00_0010_0000,
    ST_S2_SRCH = 10'b00_0100_0000,
    ST_S3      = 10'b00_1000_0000,
    ST_S4_OFS  = 10'b01_0000_0000,
    ST_END     = 10'b10_0000_0000
  } ahs_state_t;

endpackage : ahs_pkg

// *** rtl/ahs_pulse_gen.sv ***
`timescale 1ns/10ps
`include "ahs_regs.svh"
// phase accumulator: rate in pps becomes pulses per second without a divider
module ahs_pulse_gen (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // rate control
  input wire logic run_i,
  input wire logic [31:0] speed_i,
  // one-cycle step pulse
  output logic step_o
);
  logic [31:0] acc_q;
  logic [32:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, speed_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 32'h0000_0000;
      step_o <= 1'b0;
    end else if (!run_i) begin
      acc_q <= 32'h0000_0000;
      step_o <= 1'b0;
    end else if (sum >= {1'b0, `AHS_CLK_HZ}) begin
      acc_q <= 32'(sum - {1'b0, `AHS_CLK_HZ});
      step_o <= 1'b1;
    end else begin
      acc_q <= sum[31:0];
      step_o <= 1'b0;
    end
  end
endmodule : ahs_pulse_gen

// *** rtl/ahs_regs.svh ***
`ifndef AHS_REGS_SVH
`define AHS_REGS_SVH

`define AHS_CLK_MHZ 32'd100
`define AHS_CLK_HZ 32'd100000000

// apb byte offsets
`define AHS_OFS_CMD 8'h00
`define AHS_OFS_PLO 8'h04
`define AHS_OFS_PHI 8'h08
`define AHS_OFS_INLOG 8'h0c
`define AHS_OFS_STAT 8'h10
`define AHS_OFS_LPOS 8'h14
`define AHS_OFS_RPOS 8'h18
`define AHS_OFS_MODE1 8'h1c
`define AHS_OFS_MODE2 8'h20

// command register fields and codes
`define AHS_CMD_AXIS_BIT 8
`define AHS_CMD_ACCEL 8'h02
`define AHS_CMD_HISPD 8'h05
`define AHS_CMD_OFFSET 8'h06
`define AHS_CMD_LOSPD 8'h14
`define AHS_CMD_MODE1 8'h23
`define AHS_CMD_MODE2 8'h24
`define AHS_CMD_FILTER 8'h25
`define AHS_CMD_START 8'h5a

// mode word one
`define AHS_M1_S1_EN 0
`define AHS_M1_S1_DIR 1
`define AHS_M1_S1_HOME 2
`define AHS_M1_S2_LIMSEL 3
`define AHS_M1_S2_EN 4
`define AHS_M1_S2_DIR 5
`define AHS_M1_S3_EN 10
`define AHS_M1_S3_DIR 11
`define AHS_M1_S3_CCLR 12
`define AHS_M1_S3_RPCLR 13
`define AHS_M1_S3_LPCLR 14
`define AHS_M1_S4_EN 15

// mode word two
`define AHS_M2_RPCLR 1
`define AHS_M2_LPCLR 2
`define AHS_M2_CCLR_POL 3
`define AHS_M2_CCLR_W_LSB 4
`define AHS_M2_TMR_EN 7
`define AHS_M2_TMR_LSB 8

// filter word and input logic word
`define AHS_FLT_DLY_LSB 8
`define AHS_FLT_HOME_EN 2
`define AHS_FLT_MAX_CODE 4'ha
`define AHS_IL_HOME_HI 2

// timing
`define AHS_FLT_MAX_US 32'd512
`define AHS_TMR_BASE_US 32'd1
`define AHS_TMR_BASE_CYC (`AHS_TMR_BASE_US * `AHS_CLK_MHZ)
`define AHS_CCLR_BASE_US 32'd10
`define AHS_CCLR_BASE_CYC (`AHS_CCLR_BASE_US * `AHS_CLK_MHZ)

// reset values
`define AHS_RST_HISPD 32'd0
`define AHS_RST_LOSPD 32'd0
`define AHS_RST_WORD 16'h0000

`endif

// *** testbench/ahs_axis_model.sv ***
`timescale 1ns/10ps
// axis with a low-active home section and two limit zones
module ahs_axis_model #(
  parameter int SEC_LO = -60,
  parameter int SEC_HI = -40,
  parameter int LIM_LO = -150,
  parameter int LIM_HI = 100
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // drive side
  input wire logic drive_pulse_i,
  input wire logic drive_dir_minus_i,
  // position preset
  input wire logic set_i,
  input int set_pos_i,
  // sensors
  output logic home_n_o,
  output logic limit_plus_o,
  output logic limit_minus_o,
  // observation
  output int pos_o,
  output logic first_minus_o
);
  logic seen_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o <= 0;
      seen_q <= 1'b0;
      first_minus_o <= 1'b0;
    end else if (set_i) begin
      pos_o <= set_pos_i;
      seen_q <= 1'b0;
    end else if (drive_pulse_i) begin
      pos_o <= drive_dir_minus_i ? pos_o - 1 : pos_o + 1;
      seen_q <= 1'b1;
      if (!seen_q) begin
        first_minus_o <= drive_dir_minus_i;
      end
    end
  end
  // sensor is pulled low only inside its section
  assign home_n_o = !(pos_o >= SEC_LO && pos_o <= SEC_HI);
  assign limit_minus_o = pos_o <= LIM_LO;
  assign limit_plus_o = pos_o >= LIM_HI;
endmodule : ahs_axis_model

// *** testbench/ahs_home_search_assertions.sv ***
`timescale 1ns/10ps
`include "ahs_regs.svh"
module ahs_home_search_assertions #(
  parameter logic [31:0] FILT_MAX_CYC = `AHS_FLT_MAX_US * `AHS_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // motor driver
  input wire logic drive_pulse_o,
  input wire logic busy_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic cmd_wr_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_wr_q <= 1'b0;
    end else begin
      cmd_wr_q <= psel_i && penable_i && pready_o && pwrite_i && (paddr_i == `AHS_OFS_CMD);
    end
  end

  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence one_wait_s;
    !pready_o ##1 (pready_o && psel_i && penable_i);
  endsequence

  apb_wait_a: assert property (setup_s |=> one_wait_s)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  err_decode_a: assert property (pready_o |->
    pslverr_o == (paddr_i > `AHS_OFS_MODE2 || paddr_i[1:0] != 2'b00))
    else $error("error flag does not follow address map");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside answer");
  step_busy_a: assert property (drive_pulse_o |-> busy_o)
    else $error("step pulse while idle");
  step_pulse_a: assert property (drive_pulse_o |=> !drive_pulse_o)
    else $error("step pulse longer than one cycle");
  busy_cause_a: assert property ($rose(busy_o) |-> cmd_wr_q || $past(cmd_wr_q))
    else $error("search started without a command write");
  reset_quiet_a: assert property ($fell(rst_i) |-> !busy_o && !drive_pulse_o && !pready_o)
    else $error("outputs active right after reset");
endmodule : ahs_home_search_assertions

bind ahs_home_search ahs_home_search_assertions #(.FILT_MAX_CYC(FILT_MAX_CYC)) u_chk (.*);

// *** testbench/ahs_home_search_tb.sv ***
`timescale 1ns/10ps
`include "ahs_regs.svh"
module ahs_home_search_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, m2;
  logic pready, pslverr, err, home_n, lim_p, lim_m, pulse, dir_m, cclr, busy, first_minus;
  logic set_q = 1'b0;
  int set_pos = 0;
  int pos;
  int mismatches = 0;
  int samples_checked = 0;
  localparam int SEC_LO = -60;
  localparam int SEC_HI = -40;
  // overshoot, start inside, limit hit, differing step two direction, step three clears
  int starts[5] = '{0, -50, -120, 0, 0};
  logic [15:0] modes[5] = '{16'h8037, 16'h8037, 16'h8037, 16'h8017, 16'hd437};

  always #5 mclk_i = ~mclk_i;

  // short filter span keeps the run brief
  ahs_home_search #(.FILT_MAX_CYC(32'h10)) u_ahs_home_search (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .home_detect_input_i(home_n), .limit_plus_i(lim_p),
    .limit_minus_i(lim_m), .drive_pulse_o(pulse), .drive_dir_minus_o(dir_m),
    .deviation_counter_clear_output_o(cclr), .busy_o(busy));

  ahs_axis_model #(.SEC_LO(SEC_LO), .SEC_HI(SEC_HI)) u_ahs_axis_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .drive_pulse_i(pulse), .drive_dir_minus_i(dir_m),
    .set_i(set_q), .set_pos_i(set_pos), .home_n_o(home_n), .limit_plus_o(lim_p),
    .limit_minus_o(lim_m), .pos_o(pos), .first_minus_o(first_minus));

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // step two stops at the section edge that it meets first in its own direction
  function automatic int exp_end(input logic [15:0] m, input int off);
    return (m[5] ? SEC_HI : SEC_LO) + off;
  endfunction : exp_end

  // a start inside the section escapes against the step two direction first
  function automatic logic exp_first(input logic [15:0] m, input int start);
    return (start >= SEC_LO && start <= SEC_HI) ? !m[5] : m[1];
  endfunction : exp_first

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("apb ready", 32'h0, 32'h1);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  // data words first, then the command
  task automatic cmd(input logic [7:0] code, input logic [31:0] v);
    apb(1'b1, `AHS_OFS_PLO, {16'h0, v[15:0]});
    apb(1'b1, `AHS_OFS_PHI, {16'h0, v[31:16]});
    apb(1'b1, `AHS_OFS_CMD, {23'h0, 1'b1, code});
  endtask : cmd

  task automatic run(input int i);
    int n;
    int off;
    logic [31:0] lp0;
    logic [31:0] rp0;
    logic clr_seen;
    logic lclr;
    n = 0;
    clr_seen = 1'b0;
    lclr = modes[i][14] && modes[i][10];
    off = 20 + int'($urandom % 30);
    set_pos <= starts[i];
    set_q <= 1'b1;
    @(posedge mclk_i);
    set_q <= 1'b0;
    cmd(`AHS_CMD_OFFSET, off);
    cmd(`AHS_CMD_MODE1, {16'h0, modes[i]});
    apb(1'b0, `AHS_OFS_MODE1, 32'h0);
    check("mode1", rd, {16'h0, modes[i]});
    apb(1'b0, `AHS_OFS_LPOS, 32'h0);
    lp0 = rd;
    apb(1'b0, `AHS_OFS_RPOS, 32'h0);
    rp0 = rd;
    cmd(`AHS_CMD_START, 32'h0);
    apb(1'b0, `AHS_OFS_STAT, 32'h0);
    check("busy bit", {31'h0, rd[10]}, 32'h1);
    while (busy !== 1'b0 && n < 60000) begin
      @(posedge mclk_i);
      n++;
      if (cclr !== m2[3]) begin
        clr_seen = 1'b1;
      end
    end
    if (n >= 60000) begin
      check("search end", 32'h0, 32'h1);
      final_report();
    end
    // first step direction shows whether step one ran
    check("first dir", {31'h0, first_minus}, {31'h0, exp_first(modes[i], starts[i])});
    check("end pos", pos, exp_end(modes[i], off));
    // clear pulse only when step three is enabled with its output
    check("clear pulse", {31'h0, clr_seen}, {31'h0, modes[i][12] & modes[i][10]});
    apb(1'b0, `AHS_OFS_LPOS, 32'h0);
    // step three clear restarts the logical count ahead of the offset
    check("lpos delta", lclr ? rd : rd - lp0, lclr ? off : pos - starts[i]);
    apb(1'b0, `AHS_OFS_RPOS, 32'h0);
    check("rpos delta", rd - rp0, pos - starts[i]);
  endtask : run

  initial begin
    void'($urandom(32'h3309));
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    // low-active home input, filter code 1010
    apb(1'b1, `AHS_OFS_INLOG, 32'h0);
    cmd(`AHS_CMD_FILTER, 32'h0a04);
    // decel kept short: 1 pps per cycle over a 2000 pps gap
    cmd(`AHS_CMD_ACCEL, 32'd100000000);
    cmd(`AHS_CMD_HISPD, 32'd2002000);
    cmd(`AHS_CMD_LOSPD, 32'd2000000);
    // timer left disabled so step gaps stay short
    m2 = $urandom & 32'h0778;
    cmd(`AHS_CMD_MODE2, m2);
    apb(1'b0, `AHS_OFS_MODE2, 32'h0);
    check("mode2", rd, m2);
    check("clear idle", {31'h0, cclr}, {31'h0, m2[3]});
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      run(i);
    end
    final_report();
  end
endmodule : ahs_home_search_tb
